// ===== design/dso_status_out.sv
`timescale 1ns/1ps
// Behaviour
// - Relay polarity setting swaps contact pairs
// - Running indication includes DC braking
// - Each output has own function selector
// - Arrival on within 1%, off 2% below
// - Accel reach: on -1%, off +2%
// - Decel reach: on +1%, off -2%
// - Zero arrival level disables that output
// - Constant speed arrival follows active command
// - Overreach asserts above selected level pair
// - Reach asserts only at selected level
// - Run hours above limit warn
// - Power hours above limit warn
// - Limit zero disables; 10h or 100h units
// - Zero speed below programmable level
// - Sensor vector mode compares motor speed for zero speed only
module dso_status_out #(
   parameter int FREQ_W = dso_pkg::FREQ_W,
   parameter int HOURS_W = dso_pkg::HOURS_W
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_arst_n,
   // Avalon-MM slave.
   input wire logic [dso_pkg::ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [dso_pkg::DATA_W-1:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [dso_pkg::DATA_W-1:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Drive state, frequencies in 0.01 Hz units.
   input wire logic [FREQ_W-1:0] i_out_freq,
   input wire logic [FREQ_W-1:0] i_freq_command,
   input wire logic [FREQ_W-1:0] i_max_freq,
   input wire logic [FREQ_W-1:0] i_motor_speed,
   input wire logic i_running,
   input wire logic i_dc_braking,
   input wire logic i_error,
   input wire logic [HOURS_W-1:0] i_cumulative_run_hours,
   input wire logic [HOURS_W-1:0] i_cumulative_power_hours,
   // Output terminals and alarm relay.
   output logic [dso_pkg::NUM_TERM-1:0] o_term,
   output logic o_relay_contact_first_closed,
   output logic o_relay_contact_second_closed
);
   localparam int FW = dso_pkg::FUNC_W;
   localparam int NT = dso_pkg::NUM_TERM;

   // Percent of maximum frequency, used for both hysteresis margins.
   function automatic logic [FREQ_W-1:0] pct_of(input logic [FREQ_W-1:0] fmax,
                                               input int unsigned pct);
      logic [31:0] prod;
      prod = 32'(fmax) * 32'(pct);
      return FREQ_W'(prod / 32'(dso_pkg::PCT_DIV));
   endfunction

   // Byte-lane merge for register writes.
   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // Picks one indication by function code; unknown codes drive off.
   function automatic logic fsel(input logic [FW-1:0] code,
                                 input logic [dso_pkg::IND_W-1:0] ind);
      logic r;
      r = 1'b0;
      case (code)
         dso_pkg::FN_RUN: r = ind[dso_pkg::ST_RUN];
         dso_pkg::FN_CONST_SPEED: r = ind[dso_pkg::ST_FA1];
         dso_pkg::FN_OVER1: r = ind[dso_pkg::ST_FA1 + 1];
         dso_pkg::FN_ALARM: r = ind[dso_pkg::ST_ERR];
         dso_pkg::FN_REACH1: r = ind[dso_pkg::ST_FA1 + 2];
         dso_pkg::FN_OVER2: r = ind[dso_pkg::ST_FA1 + 3];
         dso_pkg::FN_REACH2: r = ind[dso_pkg::ST_FA1 + 4];
         dso_pkg::FN_RUN_HOURS: r = ind[dso_pkg::ST_RNT];
         dso_pkg::FN_POWER_HOURS: r = ind[dso_pkg::ST_ONT];
         dso_pkg::FN_ZERO_SPEED: r = ind[dso_pkg::ST_ZS];
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // Configuration registers.
   logic [1:0] pol_ff;
   logic [1:0] nxt_pol;
   logic sensor_ff;
   logic nxt_sensor;
   logic [NT*FW-1:0] term_func_ff;
   logic [NT*FW-1:0] nxt_term_func;
   logic [FW-1:0] relay_func_ff;
   logic [FW-1:0] nxt_relay_func;
   logic [FREQ_W-1:0] lvl_ff [dso_pkg::LVL_N];
   logic [FREQ_W-1:0] nxt_lvl [dso_pkg::LVL_N];
   logic [dso_pkg::LIMIT_W-1:0] hrs_lim_ff;
   logic [dso_pkg::LIMIT_W-1:0] nxt_hrs_lim;
   logic hrs_unit_ff;
   logic nxt_hrs_unit;
   // Bus handshake.
   logic ack_ff;
   logic nxt_ack;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic wr_take;
   // Indications.
   logic run_ff;
   logic nxt_run;
   logic rnt_ff;
   logic nxt_rnt;
   logic ont_ff;
   logic nxt_ont;
   logic zs_ff;
   logic nxt_zs;
   logic accel_ff;
   logic nxt_accel;
   logic [NT-1:0] term_ff;
   logic [NT-1:0] nxt_term;
   logic relay_first_ff;
   logic nxt_relay_first;
   logic relay_second_ff;
   logic nxt_relay_second;
   logic [4:0] fa;
   logic [dso_pkg::IND_W-1:0] ind;
   logic [31:0] status;
   logic [FREQ_W-1:0] fon;
   logic [FREQ_W-1:0] foff;
   logic [FREQ_W-1:0] mon_freq;
   logic [HOURS_W-1:0] hrs_thr;
   logic relay_sel;

   // One wait state per access: the request is taken on the second edge.
   always_comb begin
      nxt_ack = (i_avs_read || i_avs_write) && !ack_ff;
      o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_ff;
      wr_take = i_avs_write && ack_ff;
   end

   // Register writes and read data; unmapped addresses read zero and ignore writes.
   always_comb begin
      logic [31:0] m;
      m = 32'h0000_0000;
      nxt_pol = pol_ff;
      nxt_sensor = sensor_ff;
      nxt_term_func = term_func_ff;
      nxt_relay_func = relay_func_ff;
      nxt_lvl = lvl_ff;
      nxt_hrs_lim = hrs_lim_ff;
      nxt_hrs_unit = hrs_unit_ff;
      nxt_rdata = 32'h0000_0000;
      case (i_avs_address)
         dso_pkg::OFS_CTRL: nxt_rdata = {29'h0, sensor_ff, pol_ff};
         dso_pkg::OFS_TERM_FUNC: nxt_rdata = {2'h0, term_func_ff};
         dso_pkg::OFS_RELAY_FUNC: nxt_rdata = {26'h0, relay_func_ff};
         dso_pkg::OFS_HOURS: nxt_rdata = {15'h0, hrs_unit_ff, hrs_lim_ff};
         dso_pkg::OFS_STATUS: nxt_rdata = status;
         default: nxt_rdata = 32'h0000_0000;
      endcase
      for (int k = 0; k < dso_pkg::LVL_N; k++) begin
         if (i_avs_address == 6'(dso_pkg::OFS_LVL0 + dso_pkg::LVL_STRIDE * k)) begin
            nxt_rdata = {16'h0, lvl_ff[k]};
         end
      end
      if (wr_take) begin
         case (i_avs_address)
            dso_pkg::OFS_CTRL: begin
               m = wmerge({29'h0, sensor_ff, pol_ff}, i_avs_writedata, i_avs_byteenable);
               nxt_pol = m[1:0];
               nxt_sensor = m[dso_pkg::CTRL_SENSOR_BIT];
            end
            dso_pkg::OFS_TERM_FUNC: begin
               m = wmerge({2'h0, term_func_ff}, i_avs_writedata, i_avs_byteenable);
               nxt_term_func = m[NT*FW-1:0];
            end
            dso_pkg::OFS_RELAY_FUNC: begin
               m = wmerge({26'h0, relay_func_ff}, i_avs_writedata, i_avs_byteenable);
               nxt_relay_func = m[FW-1:0];
            end
            dso_pkg::OFS_HOURS: begin
               m = wmerge({15'h0, hrs_unit_ff, hrs_lim_ff}, i_avs_writedata,
                          i_avs_byteenable);
               nxt_hrs_lim = m[dso_pkg::LIMIT_W-1:0];
               nxt_hrs_unit = m[dso_pkg::HRS_UNIT_BIT];
            end
            default: m = 32'h0000_0000;
         endcase
         for (int k = 0; k < dso_pkg::LVL_N; k++) begin
            if (i_avs_address == 6'(dso_pkg::OFS_LVL0 + dso_pkg::LVL_STRIDE * k)) begin
               nxt_lvl[k] = FREQ_W'(wmerge({16'h0, lvl_ff[k]}, i_avs_writedata,
                                           i_avs_byteenable));
            end
         end
      end
   end

   // Bus and configuration registers.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ack_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         pol_ff <= dso_pkg::POL_RST;
         sensor_ff <= 1'b0;
         term_func_ff <= dso_pkg::TERM_FUNC_RST;
         relay_func_ff <= dso_pkg::RELAY_FUNC_RST;
         for (int k = 0; k < dso_pkg::LVL_N; k++) begin
            lvl_ff[k] <= 16'h0000;
         end
         hrs_lim_ff <= 16'h0000;
         hrs_unit_ff <= 1'b0;
      end else begin
         ack_ff <= nxt_ack;
         rdata_ff <= nxt_rdata;
         pol_ff <= nxt_pol;
         sensor_ff <= nxt_sensor;
         term_func_ff <= nxt_term_func;
         relay_func_ff <= nxt_relay_func;
         lvl_ff <= nxt_lvl;
         hrs_lim_ff <= nxt_hrs_lim;
         hrs_unit_ff <= nxt_hrs_unit;
      end
   end

   assign o_avs_readdata = rdata_ff;

   // Margins track maximum frequency so a new maximum applies at once.
   always_comb begin
      fon = pct_of(i_max_freq, dso_pkg::FON_PCT);
      foff = pct_of(i_max_freq, dso_pkg::FOFF_PCT);
   end

   // Five arrival detectors: constant speed, then overreach and reach per level pair.
   for (genvar g = 0; g < 5; g++) begin : g_arr
      logic [FREQ_W-1:0] tgt;
      logic [1:0] mode;
      logic en;
      localparam int ACC = (g < 3) ? dso_pkg::LVL_ACC1 : dso_pkg::LVL_ACC2;
      localparam int DEC = (g < 3) ? dso_pkg::LVL_DEC1 : dso_pkg::LVL_DEC2;
      always_comb begin
         if (g == 0) begin
            tgt = i_freq_command;
            mode = dso_pkg::MODE_BELOW;
            en = 1'b1;
         end else begin
            tgt = accel_ff ? lvl_ff[ACC] : lvl_ff[DEC];
            mode = (g % 2 == 1) ? dso_pkg::MODE_BELOW :
                   (accel_ff ? dso_pkg::MODE_REACH_ACC : dso_pkg::MODE_REACH_DEC);
            en = (tgt != 16'h0000);
         end
      end
      dso_arrival #(.W(FREQ_W)) u_arr (
         .i_clk(i_clk),
         .i_arst_n(i_arst_n),
         .i_freq(i_out_freq),
         .i_target(tgt),
         .i_fon(fon),
         .i_foff(foff),
         .i_mode(mode),
         .i_enable(en),
         .o_flag(fa[g])
      );
   end

   // Hour limit scaled by its unit; the largest coarse value fits in 23 bits.
   always_comb begin
      hrs_thr = hrs_unit_ff ?
                HOURS_W'(32'(hrs_lim_ff) * 32'(dso_pkg::HRS_UNIT_COARSE)) :
                HOURS_W'(32'(hrs_lim_ff) * 32'(dso_pkg::HRS_UNIT_FINE));
      mon_freq = sensor_ff ? i_motor_speed : i_out_freq;
   end

   // Indication next values; direction holds while output equals command.
   always_comb begin
      nxt_run = i_running || i_dc_braking;
      nxt_rnt = (hrs_lim_ff != 16'h0000) && (i_cumulative_run_hours > hrs_thr);
      nxt_ont = (hrs_lim_ff != 16'h0000) && (i_cumulative_power_hours > hrs_thr);
      nxt_zs = mon_freq < lvl_ff[dso_pkg::LVL_ZS];
      nxt_accel = accel_ff;
      if (i_out_freq < i_freq_command) begin
         nxt_accel = 1'b1;
      end else if (i_out_freq > i_freq_command) begin
         nxt_accel = 1'b0;
      end
   end

   // Gather the indications; the alarm input goes straight through.
   always_comb begin
      ind = {i_error, zs_ff, ont_ff, rnt_ff, fa, run_ff};
      status = {15'h0, accel_ff, relay_first_ff, term_ff, ind};
   end

   always_comb begin
      for (int t = 0; t < NT; t++) begin
         nxt_term[t] = fsel(term_func_ff[t*FW +: FW], ind);
      end
      relay_sel = fsel(relay_func_ff, ind);
      nxt_relay_first = (pol_ff == dso_pkg::POL_FIRST_ON_ERROR) ? relay_sel : !relay_sel;
      nxt_relay_second = !nxt_relay_first;
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         run_ff <= 1'b0;
         rnt_ff <= 1'b0;
         ont_ff <= 1'b0;
         zs_ff <= 1'b0;
         accel_ff <= 1'b1;
         term_ff <= 5'h00;
         relay_first_ff <= 1'b0;
         relay_second_ff <= 1'b1;
      end else begin
         run_ff <= nxt_run;
         rnt_ff <= nxt_rnt;
         ont_ff <= nxt_ont;
         zs_ff <= nxt_zs;
         accel_ff <= nxt_accel;
         term_ff <= nxt_term;
         relay_first_ff <= nxt_relay_first;
         relay_second_ff <= nxt_relay_second;
      end
   end

   assign o_term = term_ff;
   assign o_relay_contact_first_closed = relay_first_ff;
   assign o_relay_contact_second_closed = relay_second_ff;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   a_relay_error_close: assert property (
      (relay_func_ff == dso_pkg::FN_ALARM && pol_ff == dso_pkg::POL_FIRST_ON_ERROR
       && !wr_take && i_error) |=> o_relay_contact_first_closed
                                   && !o_relay_contact_second_closed)
      else $error("Relay first pair not closed on error.");
   a_relay_pairs_differ: assert property (
      o_relay_contact_first_closed != o_relay_contact_second_closed)
      else $error("Both relay pairs in same state.");
   a_run_dc_brake: assert property (
      i_dc_braking |=> status[dso_pkg::ST_RUN] ##1 (o_term[0] || term_func_ff[FW-1:0] != 6'h00
                                                     || $past(wr_take)))
      else $error("Run indication missing during DC braking.");
   a_term_overreach: assert property (
      (term_func_ff[FW-1:0] == dso_pkg::FN_OVER1 && !wr_take) |=> o_term[0] == $past(fa[1]))
      else $error("Terminal does not follow overreach flag.");
   a_const_speed_cmd: assert property (
      ({1'b0, i_out_freq} + {1'b0, fon} >= {1'b0, i_freq_command}) |=> fa[0])
      else $error("Constant speed arrival not set at command.");
   a_run_hours_warn: assert property (
      (hrs_lim_ff != 16'h0000 && i_cumulative_run_hours > hrs_thr) |=> status[dso_pkg::ST_RNT])
      else $error("Run hours warning not raised.");
   a_power_hours_warn: assert property (
      (hrs_lim_ff != 16'h0000 && i_cumulative_power_hours > hrs_thr) |=> status[dso_pkg::ST_ONT])
      else $error("Power hours warning not raised.");
   a_hours_disabled: assert property (
      (hrs_lim_ff == 16'h0000) [*2] |-> !status[dso_pkg::ST_RNT] && !status[dso_pkg::ST_ONT])
      else $error("Hour warning raised with zero limit.");
   a_zero_speed_sensor: assert property (
      (sensor_ff && i_motor_speed < lvl_ff[dso_pkg::LVL_ZS] && !wr_take) |=> zs_ff)
      else $error("Zero speed ignores motor speed in sensor mode.");
   a_zero_speed_freq: assert property (
      (!sensor_ff && i_out_freq >= lvl_ff[dso_pkg::LVL_ZS] && !wr_take) |=> !zs_ff)
      else $error("Zero speed flag set above level.");
   a_reset_unpowered: assert property (@(posedge i_clk) disable iff (1'b0)
      !i_arst_n |-> !o_relay_contact_first_closed && o_term == 5'h00)
      else $error("Outputs not deasserted in reset.");
   a_bus_one_wait: assert property (
      ((i_avs_read || i_avs_write) && o_avs_waitrequest) |=>
      (!o_avs_waitrequest || !(i_avs_read || i_avs_write)))
      else $error("Bus access waited more than one cycle.");

   c_relay_flip: cover property (relay_sel ##1 !relay_sel);
   c_reach_set: cover property (!fa[2] ##1 fa[2]);
   c_run_hours: cover property (!rnt_ff ##1 rnt_ff);
   c_write_read: cover property (wr_take ##1 i_avs_read);
endmodule

// ===== design/dso_pkg.sv
package dso_pkg;
   // Data widths.
   localparam int FREQ_W = 16;
   localparam int HOURS_W = 24;
   localparam int FUNC_W = 6;
   localparam int NUM_TERM = 5;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 32;
   localparam int LVL_N = 5;
   localparam int LIMIT_W = 16;

   // Register byte offsets.
   localparam logic [5:0] OFS_CTRL = 6'h00;
   localparam logic [5:0] OFS_TERM_FUNC = 6'h04;
   localparam logic [5:0] OFS_RELAY_FUNC = 6'h08;
   localparam logic [5:0] OFS_LVL0 = 6'h0C;
   localparam logic [5:0] OFS_HOURS = 6'h20;
   localparam logic [5:0] OFS_STATUS = 6'h24;
   localparam int LVL_STRIDE = 4;

   // Level table slots, frequencies in 0.01 Hz units.
   localparam int LVL_ACC1 = 0;
   localparam int LVL_DEC1 = 1;
   localparam int LVL_ACC2 = 2;
   localparam int LVL_DEC2 = 3;
   localparam int LVL_ZS = 4;

   // Field positions.
   localparam int CTRL_SENSOR_BIT = 2;
   localparam int HRS_UNIT_BIT = 16;

   // Reset values.
   localparam logic [1:0] POL_RST = 2'h1;
   localparam logic [FUNC_W-1:0] RELAY_FUNC_RST = 6'h05;
   localparam logic [29:0] TERM_FUNC_RST = 30'h0000_0000;

   // Relay polarity codes.
   localparam logic [1:0] POL_FIRST_ON_ERROR = 2'h0;

   // Output function codes.
   localparam logic [FUNC_W-1:0] FN_RUN = 6'h00;
   localparam logic [FUNC_W-1:0] FN_CONST_SPEED = 6'h01;
   localparam logic [FUNC_W-1:0] FN_OVER1 = 6'h02;
   localparam logic [FUNC_W-1:0] FN_ALARM = 6'h05;
   localparam logic [FUNC_W-1:0] FN_REACH1 = 6'h06;
   localparam logic [FUNC_W-1:0] FN_RUN_HOURS = 6'h0B;
   localparam logic [FUNC_W-1:0] FN_POWER_HOURS = 6'h0C;
   localparam logic [FUNC_W-1:0] FN_ZERO_SPEED = 6'h15;
   localparam logic [FUNC_W-1:0] FN_OVER2 = 6'h18;
   localparam logic [FUNC_W-1:0] FN_REACH2 = 6'h19;

   // Indication vector and status bit positions.
   localparam int ST_RUN = 0;
   localparam int ST_FA1 = 1;
   localparam int ST_RNT = 6;
   localparam int ST_ONT = 7;
   localparam int ST_ZS = 8;
   localparam int ST_ERR = 9;
   localparam int IND_W = 10;
   localparam int ST_TERM = 10;
   localparam int ST_RELAY = 15;
   localparam int ST_ACCEL = 16;

   // Arrival comparison modes.
   localparam logic [1:0] MODE_BELOW = 2'h0;
   localparam logic [1:0] MODE_REACH_ACC = 2'h1;
   localparam logic [1:0] MODE_REACH_DEC = 2'h2;

   // Hysteresis and hour scaling.
   localparam int FON_PCT = 1;
   localparam int FOFF_PCT = 2;
   localparam int PCT_DIV = 100;
   localparam int HRS_UNIT_FINE = 10;
   localparam int HRS_UNIT_COARSE = 100;
endpackage

// ===== design/dso_arrival.sv
`timescale 1ns/1ps
module dso_arrival #(
   parameter int W = dso_pkg::FREQ_W
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_arst_n,
   // Comparison inputs.
   input wire logic [W-1:0] i_freq,
   input wire logic [W-1:0] i_target,
   input wire logic [W-1:0] i_fon,
   input wire logic [W-1:0] i_foff,
   input wire logic [1:0] i_mode,
   input wire logic i_enable,
   // Arrival flag.
   output logic o_flag
);
   logic flag_ff;
   logic nxt_flag;
   logic [W:0] f_on;
   logic [W:0] f_off;
   logic [W:0] t_on;
   logic [W:0] t_off;
   logic [W:0] tgt;

   // Compare with sums so that no threshold ever goes below zero.
   always_comb begin
      f_on = {1'b0, i_freq} + {1'b0, i_fon};
      f_off = {1'b0, i_freq} + {1'b0, i_foff};
      t_on = {1'b0, i_target} + {1'b0, i_fon};
      t_off = {1'b0, i_target} + {1'b0, i_foff};
      tgt = {1'b0, i_target};
      nxt_flag = flag_ff;
      if (!i_enable) begin
         nxt_flag = 1'b0;
      end else begin
         unique case (i_mode)
            dso_pkg::MODE_BELOW: begin
               if (f_on >= tgt) begin
                  nxt_flag = 1'b1;
               end else if (f_off < tgt) begin
                  nxt_flag = 1'b0;
               end
            end
            dso_pkg::MODE_REACH_ACC: begin
               if ({1'b0, i_freq} > t_off) begin
                  nxt_flag = 1'b0;
               end else if (f_on >= tgt) begin
                  nxt_flag = 1'b1;
               end
            end
            dso_pkg::MODE_REACH_DEC: begin
               if (f_off < tgt) begin
                  nxt_flag = 1'b0;
               end else if ({1'b0, i_freq} <= t_on) begin
                  nxt_flag = 1'b1;
               end
            end
            default: nxt_flag = 1'b0;
         endcase
      end
   end

   // Flag register.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         flag_ff <= 1'b0;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   assign o_flag = flag_ff;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   a_band_turn_on: assert property (
      (i_enable && i_mode == dso_pkg::MODE_BELOW && f_on >= tgt) |=> o_flag)
      else $error("Arrival flag did not turn on near target.");
   a_reach_acc_off: assert property (
      (i_enable && i_mode == dso_pkg::MODE_REACH_ACC && {1'b0, i_freq} > t_off) |=> !o_flag)
      else $error("Reach flag stayed on above target plus margin.");
   a_reach_dec_on: assert property (
      (i_enable && i_mode == dso_pkg::MODE_REACH_DEC && f_off >= tgt
       && {1'b0, i_freq} <= t_on) |=> o_flag)
      else $error("Reach flag not on during deceleration window.");
   a_disabled_low: assert property (
      !i_enable |=> !o_flag)
      else $error("Disabled arrival flag is high.");
endmodule

// ===== dv/dso_far_model.sv
`timescale 1ns/1ps
module dso_far_model (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_arst_n,
   // Terminal levels seen on the wiring.
   input wire logic [4:0] i_term,
   // Brake request of the controller.
   output logic o_brake
);
   // brake on arrival.
   // Over-torque is not wired here, so braking stops when arrival drops.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_brake <= 1'b0;
      end else begin
         o_brake <= i_term[1];
      end
   end
endmodule

// ===== dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic i_clk = 1'b0;
   logic i_arst_n = 1'b1;
   logic [5:0] addr = 6'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic wait_req;
   logic [15:0] freq = 16'h0;
   logic [15:0] cmd = 16'h1770;
   logic [15:0] speed = 16'h0;
   logic braking = 1'b0;
   logic running = 1'b0;
   logic error = 1'b0;
   logic [23:0] run_h = 24'h0;
   logic [23:0] pwr_h = 24'h0;
   logic [4:0] term;
   logic rly1;
   logic rly2;
   logic brake;
   logic [31:0] q;
   int err_count = 0;
   int checks = 0;

   // The clock runs at 20 MHz.
   always #25 i_clk = ~i_clk;

   // Maximum frequency is fixed at 120 Hz, so the margins are 1.2 and 2.4 Hz.
   dso_status_out i_dso_status_out (.i_clk(i_clk), .i_arst_n(i_arst_n),
      .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
      .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
      .i_out_freq(freq), .i_freq_command(cmd), .i_max_freq(16'h2EE0),
      .i_motor_speed(speed), .i_running(running), .i_dc_braking(braking), .i_error(error),
      .i_cumulative_run_hours(run_h), .i_cumulative_power_hours(pwr_h), .o_term(term),
      .o_relay_contact_first_closed(rly1), .o_relay_contact_second_closed(rly2));
   dso_far_model i_dso_far_model (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_term(term),
      .o_brake(brake));

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Bus cycle that holds its request until waitrequest is sampled low at a rising edge.
   // Read data is taken at that same edge, and only then is the request dropped.
   task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n;
      @(posedge i_clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (wait_req !== 1'b0 && n < 20);
      if (n >= 20) begin
         err_count++;
         $display("[FAIL] %0t bus hang", $time);
      end
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   // Outputs follow two edges after the inputs; sampling waits three.
   task step(input logic [15:0] f);
      @(posedge i_clk);
      freq <= f;
      repeat (3) @(posedge i_clk);
      @(negedge i_clk);
   endtask

   task t_relay;
      step(16'h0000);
      chk({rly1, rly2}, 2'b10);
      @(posedge i_clk);
      error <= 1'b1;
      step(16'h0000);
      chk({rly1, rly2}, 2'b01);
      bus(1'b1, dso_pkg::OFS_CTRL, 32'h0);
      step(16'h0000);
      chk({rly1, rly2}, 2'b10);
      @(posedge i_clk);
      error <= 1'b0;
      step(16'h0000);
      chk({rly1, rly2}, 2'b01);
      bus(1'b1, dso_pkg::OFS_CTRL, 32'h1);
   endtask

   task t_arrival;
      braking <= 1'b1;
      step(16'h0000);
      chk(term[0], 1'b1);
      @(posedge i_clk);
      braking <= 1'b0;
      step(16'h16F7);
      chk(term[1:0], 2'b00);
      step(16'h16F8);
      chk(term[1], 1'b1);
      step(16'h1680);
      chk({brake, term[1]}, 2'b11);
      step(16'h167F);
      chk(term[1], 1'b0);
      @(posedge i_clk);
      cmd <= 16'h0BB8;
      step(16'h0BB8);
      chk(term[1], 1'b1);
   endtask

   task t_zero;
      bus(1'b1, 6'h1C, 32'h01F4);
      step(16'h0190);
      chk(term[2], 1'b1);
      step(16'h0258);
      chk(term[2], 1'b0);
      @(posedge i_clk);
      speed <= 16'h0258;
      bus(1'b1, dso_pkg::OFS_CTRL, 32'h5);
      step(16'h0190);
      chk(term[2], 1'b0);
      @(posedge i_clk);
      speed <= 16'h0064;
      step(16'h0258);
      chk(term[2], 1'b1);
   endtask

   task t_hours;
      bus(1'b1, dso_pkg::OFS_HOURS, 32'h5);
      run_h <= 24'h32;
      pwr_h <= 24'h33;
      step(16'h0258);
      chk(term[4:3], 2'b10);
      @(posedge i_clk);
      run_h <= 24'h33;
      step(16'h0258);
      chk(term[4:3], 2'b11);
      bus(1'b1, dso_pkg::OFS_HOURS, 32'h0001_0001);
      run_h <= 24'h65;
      pwr_h <= 24'h64;
      step(16'h0258);
      chk(term[4:3], 2'b01);
      bus(1'b1, dso_pkg::OFS_HOURS, 32'h0);
      step(16'h0258);
      chk(term[4:3], 2'b00);
   endtask

   task t_over;
      bus(1'b1, dso_pkg::OFS_TERM_FUNC, {20'h0, dso_pkg::FN_OVER1, dso_pkg::FN_RUN});
      bus(1'b1, dso_pkg::OFS_LVL0, 32'h0BB8);
      cmd <= 16'h1770;
      step(16'h1388);
      chk(term[1], 1'b1);
      bus(1'b1, dso_pkg::OFS_LVL0, 32'h0);
      step(16'h1388);
      chk(term[1], 1'b0);
   endtask

   // Reach windows in both directions and the second level pair; run drives terminal 0.
   task t_reach;
      bus(1'b1, dso_pkg::OFS_TERM_FUNC, {8'h0, dso_pkg::FN_OVER2, dso_pkg::FN_REACH2,
         dso_pkg::FN_REACH1, dso_pkg::FN_RUN});
      bus(1'b1, dso_pkg::OFS_LVL0, 32'h0BB8);
      bus(1'b1, 6'h14, 32'h0FA0);
      bus(1'b0, 6'h14, 32'h0);
      chk(q, 32'h0FA0);
      running <= 1'b1;
      step(16'h0B3F);
      chk(term[3:0], 4'h1);
      step(16'h0B40);
      chk(term[3:0], 4'h3);
      step(16'h0F28);
      chk(term[3:0], 4'hD);
      bus(1'b1, 6'h10, 32'h0BB8);
      cmd <= 16'h03E8;
      step(16'h0C31);
      chk(term[3:0], 4'h1);
      step(16'h0C30);
      chk(term[3:0], 4'h3);
      step(16'h0AC7);
      chk(term[3:0], 4'h1);
   endtask

   task end_of_test;
      if (err_count == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Watchdog sized well above the roughly 170 cycles the tests need.
   initial begin
      repeat (3000) @(posedge i_clk);
      err_count++;
      $display("[FAIL] %0t timeout", $time);
      end_of_test();
   end

   // Main sequence; reset falls at time zero so the flops clear before the first edge.
   initial begin
      i_arst_n <= 1'b0;
      @(negedge i_clk);
      chk({term, rly1, rly2}, 7'h01);
      repeat (2) @(posedge i_clk);
      i_arst_n <= 1'b1;
      bus(1'b0, dso_pkg::OFS_CTRL, 32'h0);
      chk(q, 32'h1);
      bus(1'b0, dso_pkg::OFS_RELAY_FUNC, 32'h0);
      chk(q, 32'h5);
      bus(1'b0, 6'h3C, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, dso_pkg::OFS_TERM_FUNC, {2'h0, dso_pkg::FN_POWER_HOURS,
         dso_pkg::FN_RUN_HOURS, dso_pkg::FN_ZERO_SPEED, dso_pkg::FN_CONST_SPEED,
         dso_pkg::FN_RUN});
      t_relay();
      t_arrival();
      t_zero();
      t_hours();
      t_over();
      t_reach();
      end_of_test();
   end
endmodule
